/* File: rtl/atf_top.sv */
// trigger selection, conversion sequencing and result formatting with AXI4-Lite registers
//
// Design decisions made here: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module atf_top
  import atf_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // trigger sources
  input wire logic timer0_wrap_pulse,
  input wire logic timer1_wrap_pulse,
  input wire logic timer2_period_match,
  input wire logic comparator1_synced_output,
  input wire logic comparator2_synced_output,
  input wire logic [3:0] logic_cell_output,
  // analog core
  input wire logic [9:0] conversion_result,
  output logic conversion_busy,
  // interrupt
  output logic irq
);

  logic [7:0] conv_ctrl_reg;
  logic [7:0] clk_ref_reg;
  logic [7:0] trig_cfg_reg;
  logic [7:0] result_high_reg;
  logic [7:0] result_low_reg;
  logic [2:0] irq_status_reg;
  logic [2:0] irq_mask_reg;
  logic src_sel;
  logic src_prev_reg;
  logic trig_edge;
  atf_state_type state_reg;
  logic [7:0] conv_cnt_reg;
  logic conv_done;
  logic aw_held_reg;
  logic w_held_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic wr_fire;
  logic rd_fire;
  logic sw_go;
  logic [7:0] rd_word;
  logic rd_ok;
  // write payload kept while the other channel waits
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;

  // trigger source mux; reserved codes select nothing
  always_comb begin
    unique case (trig_cfg_reg[7:TRIG_SEL_LSB])
      TRIG_T0: src_sel = timer0_wrap_pulse;
      TRIG_T1: src_sel = timer1_wrap_pulse;
      TRIG_T2: src_sel = timer2_period_match;
      TRIG_CMP1: src_sel = comparator1_synced_output;
      TRIG_CMP2: src_sel = comparator2_synced_output;
      TRIG_LC1: src_sel = logic_cell_output[0];
      TRIG_LC2: src_sel = logic_cell_output[1];
      TRIG_LC3: src_sel = logic_cell_output[2];
      TRIG_LC4: src_sel = logic_cell_output[3];
      default: src_sel = 1'b0;
    endcase
  end

  // previous level of selected source for edge detection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_prev_reg <= 1'b0;
    end else begin
      src_prev_reg <= src_sel;
    end
  end

  // a source switch from low to a high source also counts as an edge, by design
  assign trig_edge = src_sel && !src_prev_reg;

  // bus handshakes: address and data accepted independently
  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_fire = (aw_held_reg || (s_axi_awvalid && s_axi_awready)) &&
                   (w_held_reg || (s_axi_wvalid && s_axi_wready));
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign sw_go = wr_fire && (awaddr_reg == OFF_CONV_CTRL) && wstrb_reg[0] &&
                 wdata_reg[GO_BIT];

  // capture address and data, possibly in different cycles
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
    end else if (wr_fire) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) aw_held_reg <= 1'b1;
      if (s_axi_wvalid && s_axi_wready) w_held_reg <= 1'b1;
    end
  end

  // combinational view of the write payload, held or live
  always_comb begin
    awaddr_reg = aw_held_reg ? awaddr_q : s_axi_awaddr;
    wdata_reg = w_held_reg ? wdata_q : s_axi_wdata;
    wstrb_reg = w_held_reg ? wstrb_q : s_axi_wstrb;
  end

  // payload storage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) awaddr_q <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
    end
  end

  // write response, slverr for unmapped offsets
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (awaddr_reg <= OFF_IRQ_MASK && awaddr_reg[1:0] == 2'h0) ?
                     2'h0 : 2'h2;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // software-written configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_ref_reg <= CLK_REF_RST;
      trig_cfg_reg <= TRIG_CFG_RST;
      irq_mask_reg <= IRQ_RST;
    end else if (wr_fire && wstrb_reg[0]) begin
      if (awaddr_reg == OFF_CLK_REF_CFG) clk_ref_reg <= wdata_reg[7:0] & CLK_REF_WMASK;
      if (awaddr_reg == OFF_TRIG_CFG) trig_cfg_reg <= wdata_reg[7:0] & TRIG_CFG_WMASK;
      if (awaddr_reg == OFF_IRQ_MASK) irq_mask_reg <= wdata_reg[2:0];
    end
  end

  // control register; go bit is set by software or trigger, cleared at the end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      conv_ctrl_reg <= CONV_CTRL_RST;
    end else begin
      if (wr_fire && wstrb_reg[0] && awaddr_reg == OFF_CONV_CTRL) begin
        // go bit cannot be cleared by a write while busy: aborting is not offered
        conv_ctrl_reg <= (wdata_reg[7:0] & CONV_CTRL_WMASK) |
                         {6'h00, conv_ctrl_reg[GO_BIT], 1'b0};
      end
      if (conv_done) begin
        conv_ctrl_reg[GO_BIT] <= 1'b0;
      end else if (state_reg == ST_IDLE && (sw_go || trig_edge) &&
                   (conv_ctrl_reg[ENABLE_BIT] || sw_go)) begin
        conv_ctrl_reg[GO_BIT] <= 1'b1;
      end
    end
  end

  // conversion sequencer; the enable bit gates hardware triggers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_IDLE;
      conv_cnt_reg <= 8'h00;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          // edges while converting never reach here, so they are dropped
          if (sw_go || (trig_edge && conv_ctrl_reg[ENABLE_BIT])) begin
            state_reg <= ST_CONVERT;
            conv_cnt_reg <= 8'(CONV_CYCLES - 1);
          end
        end
        ST_CONVERT: begin
          if (conv_cnt_reg == 8'h00) begin
            state_reg <= ST_IDLE;
          end else begin
            conv_cnt_reg <= conv_cnt_reg - 8'h01;
          end
        end
      endcase
    end
  end

  assign conv_done = (state_reg == ST_CONVERT) && (conv_cnt_reg == 8'h00);
  assign conversion_busy = (state_reg == ST_CONVERT);

  // result pair loaded together at completion with current format
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result_high_reg <= RESULT_RST;
      result_low_reg <= RESULT_RST;
    end else if (conv_done) begin
      if (clk_ref_reg[JUSTIFY_BIT]) begin
        result_high_reg <= {6'h00, conversion_result[9:8]};
        result_low_reg <= conversion_result[7:0];
      end else begin
        result_high_reg <= conversion_result[9:2];
        result_low_reg <= {conversion_result[1:0], 6'h00};
      end
    end else if (wr_fire && wstrb_reg[0]) begin
      if (awaddr_reg == OFF_RESULT_HIGH) result_high_reg <= wdata_reg[7:0];
      if (awaddr_reg == OFF_RESULT_LOW) result_low_reg <= wdata_reg[7:0];
    end
  end

  // read mux
  always_comb begin
    rd_word = 8'h00;
    rd_ok = 1'b1;
    unique case (s_axi_araddr)
      OFF_CONV_CTRL: rd_word = conv_ctrl_reg;
      OFF_CLK_REF_CFG: rd_word = clk_ref_reg;
      OFF_TRIG_CFG: rd_word = trig_cfg_reg;
      OFF_RESULT_HIGH: rd_word = result_high_reg;
      OFF_RESULT_LOW: rd_word = result_low_reg;
      OFF_IRQ_STATUS: rd_word = {5'h00, irq_status_reg};
      OFF_IRQ_MASK: rd_word = {5'h00, irq_mask_reg};
      default: rd_ok = 1'b0;
    endcase
  end

  // read data channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rd_word};
      s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // sticky events cleared by status read; a same-cycle event wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status_reg <= IRQ_RST;
    end else begin
      irq_status_reg <= ((rd_fire && s_axi_araddr == OFF_IRQ_STATUS) ? 3'h0 : irq_status_reg) |
                        {timer1_wrap_pulse, timer0_wrap_pulse, conv_done};
    end
  end

  assign irq = |(irq_status_reg & irq_mask_reg);

  // checks
  sequence seq_start;
    (state_reg == ST_IDLE) && trig_edge && conv_ctrl_reg[ENABLE_BIT];
  endsequence

  AST_EDGE_STARTS: assert property (@(posedge aclk) disable iff (!aresetn)
    seq_start |=> conv_ctrl_reg[GO_BIT] && conversion_busy)
    else $error("trigger edge did not start conversion");
  AST_LEVEL_NO_START: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_reg == ST_IDLE) && !sw_go && !trig_edge |=> !conversion_busy)
    else $error("conversion started without edge");
  AST_GO_CLEARS: assert property (@(posedge aclk) disable iff (!aresetn)
    conv_done |=> !conv_ctrl_reg[GO_BIT])
    else $error("go bit not cleared at completion");
  AST_CONV_LEN: assert property (@(posedge aclk) disable iff (!aresetn)
    seq_start |=> conversion_busy [*8])
    else $error("conversion ended early");
  AST_TRIG_LOW_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
    trig_cfg_reg[3:0] == 4'h0)
    else $error("trigger config low bits not zero");
  AST_LEFT_FMT: assert property (@(posedge aclk) disable iff (!aresetn)
    conv_done && !clk_ref_reg[JUSTIFY_BIT] |=> result_high_reg == $past(conversion_result[9:2]))
    else $error("left justified high wrong");
  AST_LEFT_LOW: assert property (@(posedge aclk) disable iff (!aresetn)
    conv_done && !clk_ref_reg[JUSTIFY_BIT] |=> result_low_reg[5:0] == 6'h00)
    else $error("left justified low not zeroed");
  AST_RIGHT_HIGH: assert property (@(posedge aclk) disable iff (!aresetn)
    conv_done && clk_ref_reg[JUSTIFY_BIT] |=> result_high_reg[7:2] == 6'h00)
    else $error("right justified high not zeroed");
  AST_RIGHT_LOW: assert property (@(posedge aclk) disable iff (!aresetn)
    conv_done && clk_ref_reg[JUSTIFY_BIT] |=> result_low_reg == $past(conversion_result[7:0]))
    else $error("right justified low wrong");
  AST_RESULT_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    !conv_done && !wr_fire |=> $stable(result_high_reg) && $stable(result_low_reg))
    else $error("result changed outside completion");
  AST_T0_FLAG: assert property (@(posedge aclk) disable iff (!aresetn)
    timer0_wrap_pulse |=> irq_status_reg[IRQ_T0])
    else $error("timer0 flag not set");

endmodule // atf_top
`default_nettype wire

/* File: rtl/atf_pkg.sv */
// package: register map, fields, reset values and timing for the trigger/format block
package atf_pkg;
  // register byte offsets on the bus
  localparam logic [7:0] OFF_CONV_CTRL = 8'h00;
  localparam logic [7:0] OFF_CLK_REF_CFG = 8'h04;
  localparam logic [7:0] OFF_TRIG_CFG = 8'h08;
  localparam logic [7:0] OFF_RESULT_HIGH = 8'h0C;
  localparam logic [7:0] OFF_RESULT_LOW = 8'h10;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h14;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h18;
  // field positions
  localparam int TRIG_SEL_LSB = 4;
  localparam int GO_BIT = 1;
  localparam int ENABLE_BIT = 0;
  localparam int JUSTIFY_BIT = 7;
  // reset values
  localparam logic [7:0] TRIG_CFG_RST = 8'h00;
  localparam logic [7:0] CONV_CTRL_RST = 8'h00;
  localparam logic [7:0] CLK_REF_RST = 8'h00;
  localparam logic [7:0] RESULT_RST = 8'h00;
  localparam logic [2:0] IRQ_RST = 3'h0;
  // writable masks: control bit 7, clock/reference config bits 3-2 and trigger config bits 3-0 are unimplemented
  localparam logic [7:0] CONV_CTRL_WMASK = 8'h7F;
  localparam logic [7:0] CLK_REF_WMASK = 8'hF3;
  localparam logic [7:0] TRIG_CFG_WMASK = 8'hF0;
  // status bits: done, timer0 wrap, timer1 wrap
  localparam int IRQ_DONE = 0;
  localparam int IRQ_T0 = 1;
  localparam int IRQ_T1 = 2;
  // conversion time in ns at a 50 ns clock
  localparam int CONV_TIME_NS = 1100;
  localparam int CLK_PERIOD_NS = 50;
  localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // trigger source codes
  typedef enum logic [3:0] {
    TRIG_NONE = 4'h0,
    TRIG_T0 = 4'h3,
    TRIG_T1 = 4'h4,
    TRIG_T2 = 4'h5,
    TRIG_CMP1 = 4'h6,
    TRIG_CMP2 = 4'h7,
    TRIG_LC1 = 4'h8,
    TRIG_LC2 = 4'h9,
    TRIG_LC3 = 4'hA,
    TRIG_LC4 = 4'hB
  } atf_trig_type;
  // converter states
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_CONVERT = 1'b1
  } atf_state_type;
endpackage

/* File: test/atf_src_model.sv */
// stand-in for the trigger sources and the analog core next to the block
`timescale 1ns/10ps
`default_nettype none
module atf_src_model (
  // clock
  input wire logic aclk,
  // bench requests: one bit per source, the value to convert
  input wire logic [8:0] fire,
  input wire logic [9:0] value,
  input wire logic busy,
  // trigger sources
  output logic timer0_wrap_pulse,
  output logic timer1_wrap_pulse,
  output logic timer2_period_match,
  output logic comparator1_synced_output,
  output logic comparator2_synced_output,
  output logic [3:0] logic_cell_output,
  // analog core
  output logic [9:0] conversion_result
);
  // sources re-timed like real peripherals; low unless the bench asks
  always_ff @(posedge aclk) begin
    {logic_cell_output, comparator2_synced_output, comparator1_synced_output,
     timer2_period_match, timer1_wrap_pulse, timer0_wrap_pulse} <= fire;
  end
  // core output only valid while converting; inverted otherwise to catch early sampling
  assign conversion_result = busy ? value : ~value;
endmodule // atf_src_model
`default_nettype wire

/* File: test/tb.sv */
// self-checking bench: registers, formats, interrupt and triggers
`timescale 1ns/10ps
`default_nettype none
module tb;
  import atf_pkg::*;
  localparam int LIM = 40;
  localparam int ACQ_CYCLES = 100;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, busy, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [8:0] fire = 9'h000;
  logic [9:0] value = 10'h000;
  logic t0, t1, t2, c1, c2;
  logic [3:0] lc;
  logic [9:0] res;
  int failures = 0;
  int checks = 0;
  always #25 aclk = ~aclk;
  atf_src_model atf_src_model_i (.aclk(aclk), .fire(fire), .value(value), .busy(busy),
    .timer0_wrap_pulse(t0), .timer1_wrap_pulse(t1), .timer2_period_match(t2),
    .comparator1_synced_output(c1), .comparator2_synced_output(c2),
    .logic_cell_output(lc), .conversion_result(res));
  atf_top atf_top_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .timer0_wrap_pulse(t0), .timer1_wrap_pulse(t1), .timer2_period_match(t2),
    .comparator1_synced_output(c1), .comparator2_synced_output(c2),
    .logic_cell_output(lc), .conversion_result(res), .conversion_busy(busy), .irq(irq));
  task automatic end_of_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask
  // a wait that ran out ends the run at once
  task automatic guard(input int n);
    if (n >= LIM) begin
      failures++;
      $display("unexpected wait: expected answer seen timeout");
      end_of_test();
    end
  endtask
  // write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] resp);
    int n;
    bit aw_done, w_done;
    n = 0;
    aw_done = 0;
    w_done = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done) && n < LIM) begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) begin
        aw_done = 1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w_done = 1;
        wvalid <= 1'b0;
      end
    end
    guard(n);
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (!bvalid && n < LIM);
    guard(n);
    resp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (!arready && n < LIM);
    guard(n);
    arvalid <= 1'b0;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (!rvalid && n < LIM);
    guard(n);
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    check(name, exp, d);
    check("read resp", 32'h0, {30'h0, r});
  endtask
  // count cycles until busy reaches lvl, bounded
  task automatic wait_busy(input logic lvl, output int n);
    n = 0;
    while (busy !== lvl && n < LIM) begin
      @(posedge aclk);
      n++;
    end
  endtask
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    rd_chk("trig cfg reset", OFF_TRIG_CFG, 32'h0);
    wr(OFF_TRIG_CFG, 8'hFF, r);
    check("write resp", 32'h0, {30'h0, r});
    rd_chk("trig cfg low nibble", OFF_TRIG_CFG, 32'hF0);
    rd(8'h1C, d, r);
    check("unmapped resp", 32'h2, {30'h0, r});
    wr(8'h1C, 8'h00, r);
    check("unmapped write resp", 32'h2, {30'h0, r});
    wr(OFF_TRIG_CFG, 8'h00, r);
    $display("test regs done");
  endtask
  task automatic t_format;
    logic [1:0] r;
    logic [9:0] v;
    int n;
    for (int j = 0; j < 2; j++) begin
      v = j ? 10'h2A5 : 10'h15A;
      value <= v;
      wr(OFF_CLK_REF_CFG, {j[0], 7'h00}, r);
      repeat (ACQ_CYCLES) @(posedge aclk);
      wr(OFF_CONV_CTRL, 8'h03, r);
      // busy rose at the edge the write was taken; counted from the response edge
      wait_busy(1'b0, n);
      guard(n);
      check("busy cycles", CONV_CYCLES, n);
      rd_chk("go cleared", OFF_CONV_CTRL, 32'h01);
      if (j) begin
        rd_chk("right high", OFF_RESULT_HIGH, {30'h0, v[9:8]});
        rd_chk("right low", OFF_RESULT_LOW, {24'h0, v[7:0]});
      end else begin
        rd_chk("left high", OFF_RESULT_HIGH, {24'h0, v[9:2]});
        rd_chk("left low", OFF_RESULT_LOW, {24'h0, v[1:0], 6'h00});
      end
    end
    $display("test format done");
  endtask
  task automatic t_irq;
    logic [1:0] r;
    wr(OFF_IRQ_MASK, 8'h01, r);
    repeat (2) @(posedge aclk);
    check("irq raised", 32'h1, {31'h0, irq});
    rd_chk("status done", OFF_IRQ_STATUS, 32'h01);
    repeat (2) @(posedge aclk);
    check("irq cleared", 32'h0, {31'h0, irq});
    rd_chk("status empty", OFF_IRQ_STATUS, 32'h00);
    $display("test irq done");
  endtask
  // every code: real sources start a conversion, none and reserved do not
  task automatic t_trig;
    logic [1:0] r;
    int n;
    // converter disabled: a real edge must not start anything
    wr(OFF_CONV_CTRL, 8'h00, r);
    wr(OFF_TRIG_CFG, {TRIG_T2, 4'h0}, r);
    fire <= 9'h004;
    @(posedge aclk);
    fire <= 9'h000;
    repeat (4) @(posedge aclk);
    check("disabled no start", 32'h0, {31'h0, busy});
    wr(OFF_CONV_CTRL, 8'h01, r);
    for (int c = 0; c < 16; c++) begin
      wr(OFF_TRIG_CFG, {c[3:0], 4'h0}, r);
      fire <= (c >= 3 && c <= 11) ? 9'h001 << (c - 3) : 9'h1FF;
      @(posedge aclk);
      fire <= 9'h000;
      repeat (4) @(posedge aclk);
      check("trigger start", {31'h0, c >= 3 && c <= 11}, {31'h0, busy});
      wait_busy(1'b0, n);
      guard(n);
    end
    rd_chk("timer flags", OFF_IRQ_STATUS, 32'h07);
    // level held through and past a conversion: exactly one start
    wr(OFF_TRIG_CFG, {TRIG_T2, 4'h0}, r);
    fire <= 9'h004;
    repeat (4) @(posedge aclk);
    check("level start", 32'h1, {31'h0, busy});
    wait_busy(1'b0, n);
    guard(n);
    repeat (6) @(posedge aclk);
    check("level no restart", 32'h0, {31'h0, busy});
    fire <= 9'h000;
    // second edge inside a running conversion must not stretch it
    repeat (2) @(posedge aclk);
    fire <= 9'h004;
    @(posedge aclk);
    fire <= 9'h000;
    repeat (5) @(posedge aclk);
    fire <= 9'h004;
    @(posedge aclk);
    fire <= 9'h000;
    wait_busy(1'b0, n);
    guard(n);
    check("edge while busy", CONV_CYCLES - 4, n);
    $display("test trig done");
  endtask
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_format();
    t_irq();
    t_trig();
    end_of_test();
  end
endmodule // tb
`default_nettype wire
